//--- bench/mts_asserts.sv
module mts_asserts
  import mts_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire mts_cmd_t cmd,
  input wire mts_cfg_t cfg,
  input wire logic interval_load,
  input wire logic [TIME_W-1:0] interval_value,
  input wire mts_conv_t conv_result,
  input wire logic conv_start,
  input wire logic chan_open,
  input wire logic chan_close,
  input wire logic reading_valid,
  input wire logic beep,
  input wire logic idle,
  input wire logic cont_mode,
  input wire logic [TIME_W-1:0] interval_ms
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Beep burst and channel step shapes
  sequence s_beep_burst;
    beep [*4] ##1 !beep;
  endsequence
  sequence s_chan_step;
    ##[1:2] chan_close;
  endsequence
  a_idle_quiet:
    assert property (idle && $past(idle) && $past(idle, 2) |-> !conv_start && !chan_close)
    else $error("activity while idle");
  a_init_leave:
    assert property (idle && cmd.initiate && !cmd.to_idle |=> !idle)
    else $error("initiate did not leave idle");
  a_cont_set:
    assert property (cmd.cont_on && !cmd.cont_off && !cmd.to_idle |=> cont_mode)
    else $error("continuous mode not set");
  a_abort_idle:
    assert property (cmd.to_idle |-> ##[1:2] idle)
    else $error("abort did not reach idle");
  a_imm_start:
    assert property (idle && cmd.initiate && !cmd.to_idle && cfg.source == MTS_SRC_IMM
      && !cfg.sweep_mode && !cfg.scan_en |-> ##4 conv_start)
    else $error("immediate start late");
  a_one_reading:
    assert property (conv_result.valid && !cfg.repeat_filter && !cfg.hold_en && !idle
      && !cmd.to_idle && !$past(cmd.to_idle) |=> reading_valid)
    else $error("no reading after conversion");
  a_beep_len:
    assert property ($rose(beep) |-> s_beep_burst)
    else $error("beep length wrong");
  a_chan_order:
    assert property (chan_open |-> s_chan_step)
    else $error("open not followed by close");
  a_interval_rst:
    assert property ($fell(srst) |-> interval_ms == INTERVAL_RST)
    else $error("interval reset value wrong");
  a_interval_floor:
    assert property (interval_load && interval_value < INTERVAL_FLOOR |=>
      interval_ms == INTERVAL_FLOOR)
    else $error("interval below floor");
  a_interval_ceiling:
    assert property (interval_load && interval_value > TIME_MAX |=> interval_ms == TIME_MAX)
    else $error("interval above ceiling");
endmodule : mts_asserts

bind mts_sequencer mts_asserts i_chk (.clk_sys(clk_sys), .srst(srst), .cmd(cmd), .cfg(cfg),
  .interval_load(interval_load), .interval_value(interval_value),
  .conv_result(conv_result), .conv_start(conv_start), .chan_open(chan_open),
  .chan_close(chan_close), .reading_valid(reading_valid), .beep(beep), .idle(idle),
  .cont_mode(cont_mode), .interval_ms(interval_ms));

//--- bench/mts_conv_model.sv
module mts_conv_model
  import mts_pkg::*;
(
  input wire logic clk_sys,
  input wire logic conv_start,
  input wire logic [3:0] lat,
  input wire logic signed [31:0] val,
  output mts_conv_t conv_result
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = -1;
  initial conv_result = '0;
  // Converter answers after lat cycles; data toggles when not valid
  always @(posedge clk_sys) begin
    conv_result.valid <= 1'b0;
    conv_result.value <= ~conv_result.value;
    if (conv_start) cnt = lat;
    else if (cnt > 0) cnt = cnt - 1;
    if (cnt == 0) begin
      conv_result.valid <= 1'b1;
      conv_result.value <= val;
      cnt = -1;
    end
  end
endmodule : mts_conv_model

//--- bench/mts_sequencer_bench.sv
module mts_sequencer_bench;
  import mts_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  mts_cmd_t cmd = '0;
  mts_cfg_t cfg = '0;
  logic interval_load = 1'b0;
  logic [TIME_W-1:0] ival = '0;
  logic spare_ok = 1'b0;
  logic key = 1'b0;
  logic remote = 1'b0;
  logic ext = 1'b0;
  logic outlier = 1'b0;
  logic close_d = 1'b0;
  logic [3:0] lat = 4'h1;
  logic signed [31:0] val = 32'sh0;
  mts_conv_t conv_result;
  logic conv_start, chan_open, chan_close, reading_valid, beep, idle;
  logic [7:0] chan_index;
  logic signed [31:0] reading;
  int bad_count = 0;
  int n_compared = 0;
  int n_conv = 0;
  int cyc = 0;
  int t0 = 0;
  int t_first = 0;
  int conv_at_beep = 0;
  int seed = 32'h0E541F27;
  logic signed [31:0] exp_q[$];
  logic [7:0] chan_q[$];

  always #12.5 clk_sys = ~clk_sys;

  mts_sequencer #(.MS_DIV(4), .CHAN_W(8)) i_dut (.clk_sys(clk_sys), .srst(srst), .cmd(cmd),
    .cfg(cfg), .interval_load(interval_load), .interval_value(ival),
    .front_panel_fire_key(key), .remote_mode(remote), .ext_trigger_in(ext),
    .scan_last_chan(8'h02), .conv_result(conv_result), .conv_start(conv_start),
    .chan_open(chan_open), .chan_close(chan_close), .chan_index(chan_index),
    .reading_valid(reading_valid), .reading(reading), .beep(beep), .idle(idle),
    .cont_mode(), .interval_ms());

  mts_conv_model i_conv (.clk_sys(clk_sys), .conv_start(conv_start), .lat(lat), .val(val),
    .conv_result(conv_result));

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", what, e, s);
    end
  endtask : chk

  task automatic final_report;
    if (bad_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick

  task automatic pulse(input logic [4:0] m);
    cmd = mts_cmd_t'(m);
    tick(1);
    cmd = '0;
  endtask : pulse

  // One trigger flow from source s, expecting n readings
  task automatic shot(input logic [2:0] s, input int n);
    cfg.source = s;
    val = $random(seed) % 5000;
    lat = 4'(($random(seed) & 5) + 1);
    n_conv = 0;
    conv_at_beep = 0;
    repeat (n) exp_q.push_back(val);
    t0 = cyc;
    pulse(5'h10);
    tick(6);
    key = (s == 3'h1);
    ext = (s == 3'h3);
    cmd.bus_trigger = (s == 3'h4);
    tick(1);
    cmd.bus_trigger = 1'b0;
    tick(3);
    key = 1'b0;
    ext = 1'b0;
    for (int i = 0; i < 300 && !idle; i++) tick(1);
    pulse(5'h02);
    tick(2);
    chk("missing readings", 0, exp_q.size());
  endtask : shot

  // Scoreboard and event counters
  always @(posedge clk_sys) begin
    cyc++;
    close_d <= chan_close;
    if (close_d) chan_q.push_back(chan_index);
    if (conv_start) begin
      if (n_conv == 0) t_first = cyc;
      n_conv++;
    end
    if (beep && conv_at_beep == 0) conv_at_beep = n_conv;
    // Readings with no note are refused outside the hold and scan runs
    if (reading_valid) begin
      if (exp_q.size() > 0) chk("reading", exp_q.pop_front(), reading);
      else if (!spare_ok) chk("unexpected reading", 0, 1);
    end
  end

  // Hold outlier source
  always @(negedge clk_sys) if (outlier) val <= (n_conv == 2) ? 32'sd9000 : 32'sd1000;

  // Main sequence
  initial begin
    cfg.hold_window = 12'h064;
    cfg.hold_count = 7'h02;
    cfg.filter_count = 7'h04;
    cfg.point_count = 16'h0002;
    cfg.delay_ms = 30'h2;
    cfg.auto_delay_ms = 30'h3;
    repeat (2) @(negedge clk_sys);
    srst = 1'b0;
    ival = '1;
    interval_load = 1'b1;
    tick(1);
    ival = '0;
    tick(1);
    interval_load = 1'b0;
    for (int s = 0; s < 5; s++) begin
      remote = 1'b1;
      shot(3'(s), (s == 1 || s == 2) ? 0 : 1);
      remote = 1'b0;
      shot(3'(s), (s == 2) ? 0 : 1);
    end
    cfg.repeat_filter = 1'b1;
    shot(3'h0, 1);
    chk("filter conversions", 4, n_conv);
    cfg.repeat_filter = 1'b0;
    cfg.sweep_mode = 1'b1;
    for (int a = 0; a < 2; a++) begin
      cfg.auto_delay = a[0];
      shot(3'h0, 2);
      chk("sweep points", 2, n_conv);
      chk("delay length", 1, (t_first - t0) >= (8 + 4 * a));
    end
    cfg.auto_delay = 1'b0;
    cfg.delay_ms = 30'h14;
    n_conv = 0;
    pulse(5'h10);
    tick(20);
    pulse(5'h02);
    tick(120);
    chk("abort in delay", 0, n_conv);
    cfg.sweep_mode = 1'b0;
    spare_ok = 1'b1;
    cfg.hold_en = 1'b1;
    shot(3'h0, 0);
    chk("hold conversions", 3, conv_at_beep);
    outlier = 1'b1;
    shot(3'h0, 0);
    chk("reseed", 1, conv_at_beep > 3);
    outlier = 1'b0;
    cfg.hold_en = 1'b0;
    cfg.scan_en = 1'b1;
    cfg.source = 3'h2;
    chan_q.delete();
    pulse(5'h08);
    for (int i = 0; i < 400 && chan_q.size() < 5; i++) tick(1);
    pulse(5'h02);
    for (int i = 0; i < 5; i++) chk("channel", i % 3, chan_q[i]);
    tick(5);
    final_report();
  end

  // Watchdog
  initial begin
    #(25ns * 40000);
    bad_count++;
    final_report();
  end
endmodule : mts_sequencer_bench

//--- hw/mts_sequencer.sv
module mts_sequencer
  import mts_pkg::*;
#(
  parameter int unsigned MS_DIV = MS_CYCLES,
  parameter int unsigned CHAN_W = 8
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire mts_cmd_t cmd,
  input wire mts_cfg_t cfg,
  input wire logic interval_load,
  input wire logic [TIME_W-1:0] interval_value,
  input wire logic front_panel_fire_key,
  input wire logic remote_mode,
  input wire logic ext_trigger_in,
  input wire logic [CHAN_W-1:0] scan_last_chan,
  input wire mts_conv_t conv_result,
  output logic conv_start,
  output logic chan_open,
  output logic chan_close,
  output logic [CHAN_W-1:0] chan_index,
  output logic reading_valid,
  output logic signed [31:0] reading,
  output logic beep,
  output logic idle,
  output logic cont_mode,
  output logic [TIME_W-1:0] interval_ms
);

  mts_state_t state;
  mts_state_t next_state;

  // Pin synchronisers, three stages each
  logic [2:0] key_sync;
  logic [2:0] ext_sync;
  logic key_seen;
  logic ext_seen;

  logic [MS_CNT_W-1:0] ms_div;
  logic [TIME_W-1:0] delay_cnt;
  logic [TIME_W-1:0] timer_cnt;
  logic timer_first;
  logic chan_valid;
  logic [6:0] filt_cnt;
  logic signed [39:0] filt_acc;
  logic signed [31:0] seed;
  logic [6:0] hold_cnt;
  logic seed_taken;
  logic [15:0] point_cnt;
  logic [2:0] beep_cnt;

  // Command decode
  wire go_idle = cmd.to_idle;
  wire leave_idle = cmd.initiate | cmd.cont_on;
  wire ms_tick = (ms_div == MS_CNT_W'(MS_DIV - 1));

  // Edge detect on the agreeing later stages of the synchronisers
  wire key_edge = key_sync[1] & key_sync[2] & ~key_seen;
  wire ext_edge = ext_sync[1] & ext_sync[2] & ~ext_seen;
  wire key_fall = ~key_sync[1] & ~key_sync[2];
  wire ext_fall = ~ext_sync[1] & ~ext_sync[2];

  // Interval source usable only when scanning
  wire timer_src = (cfg.source == MTS_SRC_TIMER) & cfg.scan_en;
  wire timer_due = timer_first | (timer_cnt == '0);

  // Event detection per source
  wire src_imm = (cfg.source == MTS_SRC_IMM);
  wire src_key = (cfg.source == MTS_SRC_KEY) & key_edge & ~remote_mode;
  wire src_tmr = timer_src & timer_due;
  wire src_ext = (cfg.source == MTS_SRC_EXT) & ext_edge;
  wire src_bus = (cfg.source == MTS_SRC_BUS) & cmd.bus_trigger;
  wire event_hit = src_imm | src_key | src_tmr | src_ext | src_bus;

  // Delay selection; sweep mode uses delay, fixed mode skips it
  wire [TIME_W-1:0] delay_sel = cfg.auto_delay ? cfg.auto_delay_ms : cfg.delay_ms;
  wire skip_delay = ~cfg.sweep_mode | (delay_sel == '0);

  // Conversion count per reading
  wire [6:0] conv_need = cfg.repeat_filter ? cfg.filter_count : 7'h01;
  wire filt_last = (filt_cnt + 7'h01 >= conv_need);
  wire signed [39:0] acc_next = filt_acc + 40'(conv_result.value);
  wire signed [31:0] filt_val = 32'(acc_next / $signed({33'h0, conv_need}));

  // Window test: |x - seed| * 10000 <= |seed| * window
  wire signed [32:0] diff = 33'(reading) - 33'(seed); // Latched reading, stable in hold check
  wire [32:0] diff_abs = diff[32] ? 33'(-diff) : diff;
  wire [31:0] seed_abs = seed[31] ? 32'(-seed) : 32'(seed);
  wire [47:0] lhs = 48'(diff_abs) * 48'd10000;
  wire [47:0] rhs = 48'(seed_abs) * 48'(cfg.hold_window);
  wire in_window = (lhs <= rhs);
  wire [6:0] hold_need = (cfg.hold_count < HOLD_CNT_MIN) ? HOLD_CNT_MIN :
                         (cfg.hold_count > HOLD_CNT_MAX) ? HOLD_CNT_MAX : cfg.hold_count;
  wire hold_done = seed_taken & in_window & (hold_cnt + 7'h01 >= hold_need);

  // Sweep point bookkeeping
  wire points_done = ~cfg.sweep_mode | (point_cnt + 16'h0001 >= cfg.point_count);
  wire [CHAN_W-1:0] chan_next = (chan_index >= scan_last_chan) ? '0 : chan_index + 1'b1;

  // Interval setting clamped to its legal range
  wire [TIME_W-1:0] interval_clamp = (interval_value < INTERVAL_FLOOR) ? INTERVAL_FLOOR :
                                     (interval_value > TIME_MAX) ? TIME_MAX : interval_value;

  // Next state
  always_comb begin
    next_state = state;
    case (state)
      MTS_IDLE: begin
        if (leave_idle) begin
          next_state = MTS_DETECT;
        end
      end
      MTS_DETECT: begin
        if (event_hit) begin
          next_state = skip_delay ? MTS_CHAN_OPEN : MTS_DELAY;
        end
      end
      MTS_DELAY: begin
        if (delay_cnt == '0) begin
          next_state = MTS_CHAN_OPEN;
        end
      end
      MTS_CHAN_OPEN: begin
        next_state = cfg.scan_en ? MTS_CHAN_CLOSE : MTS_CONV;
      end
      MTS_CHAN_CLOSE: begin
        next_state = MTS_CONV;
      end
      MTS_CONV: begin
        next_state = MTS_CONV_WAIT;
      end
      MTS_CONV_WAIT: begin
        if (conv_result.valid) begin
          if (!filt_last) begin
            next_state = MTS_CONV;
          end else if (cfg.hold_en) begin
            next_state = MTS_HOLD_CHK;
          end else begin
            next_state = MTS_DONE;
          end
        end
      end
      MTS_HOLD_CHK: begin
        next_state = hold_done ? MTS_DONE : MTS_CONV;
      end
      MTS_DONE: begin
        if (!points_done) begin
          next_state = MTS_DETECT;
        end else begin
          next_state = cont_mode ? MTS_DETECT : MTS_IDLE;
        end
      end
      default: begin
        next_state = MTS_IDLE;
      end
    endcase
    if (go_idle) begin
      next_state = MTS_IDLE;
    end
  end

  // State register and continuous flag
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= MTS_IDLE;
      cont_mode <= 1'b0;
    end else begin
      state <= next_state;
      if (go_idle | cmd.cont_off) begin
        cont_mode <= 1'b0;
      end else if (cmd.cont_on) begin
        cont_mode <= 1'b1;
      end
    end
  end

  // Pin synchronisers and one-shot latches
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      key_sync <= '0;
      ext_sync <= '0;
      key_seen <= 1'b0;
      ext_seen <= 1'b0;
    end else begin
      key_sync <= {key_sync[1:0], front_panel_fire_key};
      ext_sync <= {ext_sync[1:0], ext_trigger_in};
      key_seen <= key_edge ? 1'b1 : (key_fall ? 1'b0 : key_seen);
      ext_seen <= ext_edge ? 1'b1 : (ext_fall ? 1'b0 : ext_seen);
    end
  end

  // Millisecond tick
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ms_div <= '0;
    end else begin
      ms_div <= ms_tick ? '0 : ms_div + 1'b1;
    end
  end

  // Interval setting register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      interval_ms <= INTERVAL_RST;
    end else if (interval_load) begin
      interval_ms <= interval_clamp;
    end
  end

  // Interval timer; reset in idle or outside scan
  always_ff @(posedge clk_sys) begin
    if (srst || state == MTS_IDLE || !cfg.scan_en) begin
      timer_first <= 1'b1;
      timer_cnt <= '0;
    end else if (state == MTS_DETECT && src_tmr) begin
      timer_first <= 1'b0;
      timer_cnt <= interval_ms;
    end else if (ms_tick && timer_cnt != '0) begin
      timer_cnt <= timer_cnt - 1'b1;
    end
  end

  // Delay countdown
  always_ff @(posedge clk_sys) begin
    if (srst || go_idle) begin
      delay_cnt <= '0;
    end else if (state == MTS_DETECT && event_hit) begin
      delay_cnt <= delay_sel;
    end else if (state == MTS_DELAY && ms_tick && delay_cnt != '0) begin
      delay_cnt <= delay_cnt - 1'b1;
    end
  end

  // Channel stepping
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      chan_open <= 1'b0;
      chan_close <= 1'b0;
      chan_valid <= 1'b0;
      chan_index <= '0;
    end else begin
      chan_open <= (state == MTS_CHAN_OPEN) & cfg.scan_en & chan_valid;
      chan_close <= (state == MTS_CHAN_CLOSE) & ~go_idle;
      if (state == MTS_CHAN_CLOSE && !go_idle) begin
        chan_index <= chan_valid ? chan_next : '0;
        chan_valid <= 1'b1;
      end else if (state == MTS_IDLE) begin
        chan_valid <= 1'b0;
      end
    end
  end

  // Conversion and filtering
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      conv_start <= 1'b0;
      filt_cnt <= '0;
      filt_acc <= '0;
      reading_valid <= 1'b0;
      reading <= '0;
    end else begin
      conv_start <= (state == MTS_CONV) & ~go_idle;
      reading_valid <= 1'b0;
      if (state == MTS_CONV_WAIT && conv_result.valid && !go_idle) begin
        if (filt_last) begin
          filt_cnt <= '0;
          filt_acc <= '0;
          reading <= filt_val;
          reading_valid <= 1'b1;
        end else begin
          filt_cnt <= filt_cnt + 1'b1;
          filt_acc <= acc_next;
        end
      end else if (state == MTS_IDLE) begin
        filt_cnt <= '0;
        filt_acc <= '0;
      end
    end
  end

  // Hold qualification
  always_ff @(posedge clk_sys) begin
    if (srst || go_idle || state == MTS_IDLE) begin
      seed_taken <= 1'b0;
      hold_cnt <= '0;
      seed <= '0;
    end else if (state == MTS_HOLD_CHK) begin
      if (!seed_taken || !in_window) begin
        seed <= reading;
        seed_taken <= 1'b1;
        hold_cnt <= '0;
      end else if (hold_done) begin
        seed_taken <= 1'b0;
        hold_cnt <= '0;
      end else begin
        hold_cnt <= hold_cnt + 1'b1;
      end
    end
  end

  // Sweep point count and beep
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      point_cnt <= '0;
      beep_cnt <= '0;
      beep <= 1'b0;
    end else begin
      if (state == MTS_IDLE || (state == MTS_DONE && points_done)) begin
        point_cnt <= '0;
      end else if (state == MTS_DONE) begin
        point_cnt <= point_cnt + 1'b1;
      end
      if (state == MTS_HOLD_CHK && hold_done && !go_idle) begin
        beep_cnt <= 3'(BEEP_CYCLES);
      end else if (beep_cnt != '0) begin
        beep_cnt <= beep_cnt - 1'b1;
      end
      beep <= (beep_cnt != '0);
    end
  end

  // Idle status
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      idle <= 1'b1;
    end else begin
      idle <= (next_state == MTS_IDLE);
    end
  end

endmodule : mts_sequencer

//--- pkg/mts_pkg.sv
package mts_pkg;

  // Clock rate
  localparam int unsigned CLK_HZ = 40000000;
  // Interval timer figures in milliseconds
  localparam int unsigned INTERVAL_DEFAULT_MS = 100;
  localparam int unsigned INTERVAL_MIN_MS = 1;
  localparam longint unsigned INTERVAL_MAX_MS = 64'd999999999;
  // Cycles per millisecond tick
  localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
  localparam int unsigned MS_CNT_W = 16;
  // Time fields carry milliseconds; 30 bits hold 999999999
  localparam int unsigned TIME_W = 30;
  localparam logic [TIME_W-1:0] TIME_MAX = TIME_W'(INTERVAL_MAX_MS);
  localparam logic [TIME_W-1:0] INTERVAL_RST = TIME_W'(INTERVAL_DEFAULT_MS);
  localparam logic [TIME_W-1:0] INTERVAL_FLOOR = TIME_W'(INTERVAL_MIN_MS);
  // Hold count limits
  localparam logic [6:0] HOLD_CNT_MIN = 7'h02;
  localparam logic [6:0] HOLD_CNT_MAX = 7'h64;
  // Window limits in hundredths of a percent
  localparam logic [11:0] HOLD_WIN_MIN = 12'h001;
  localparam logic [11:0] HOLD_WIN_MAX = 12'h7D0;
  // Beep pulse length in cycles
  localparam int unsigned BEEP_CYCLES = 4;

  // Event source selection
  typedef enum logic [2:0] {
    MTS_SRC_IMM,
    MTS_SRC_KEY,
    MTS_SRC_TIMER,
    MTS_SRC_EXT,
    MTS_SRC_BUS
  } mts_src_t;

  // Sequencer states
  typedef enum logic [3:0] {
    MTS_IDLE,
    MTS_DETECT,
    MTS_DELAY,
    MTS_CHAN_OPEN,
    MTS_CHAN_CLOSE,
    MTS_CONV,
    MTS_CONV_WAIT,
    MTS_HOLD_CHK,
    MTS_DONE
  } mts_state_t;

  // Host commands, each a one-cycle pulse
  typedef struct packed {
    logic initiate;
    logic cont_on;
    logic cont_off;
    logic to_idle;
    logic bus_trigger;
  } mts_cmd_t;

  // Static configuration
  typedef struct packed {
    logic [2:0] source;
    logic [TIME_W-1:0] interval_ms;
    logic [TIME_W-1:0] delay_ms;
    logic auto_delay;
    logic [TIME_W-1:0] auto_delay_ms;
    logic repeat_filter;
    logic [6:0] filter_count;
    logic hold_en;
    logic [11:0] hold_window;
    logic [6:0] hold_count;
    logic scan_en;
    logic sweep_mode;
    logic [15:0] point_count;
  } mts_cfg_t;

  // Conversion result from the converter
  typedef struct packed {
    logic valid;
    logic signed [31:0] value;
  } mts_conv_t;

endpackage : mts_pkg
